/* File: rtl/link_regs_pkg.sv */
package link_regs_pkg;

  // ==========================================================================
  // Register indices (printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it)
  localparam logic [11:0] idx_link_enable          = 12'h200;
  localparam logic [11:0] idx_output_mode          = 12'h201;
  localparam logic [11:0] idx_multiframe_length    = 12'h202;
  localparam logic [11:0] idx_manual_sync_request  = 12'h203;
  localparam logic [11:0] idx_link_control         = 12'h204;
  localparam logic [11:0] idx_test_pattern_control = 12'h205;
  localparam logic [11:0] idx_device_identifier    = 12'h206;
  localparam logic [11:0] idx_frame_character      = 12'h207;
  localparam logic [11:0] idx_link_system_status   = 12'h208;
  localparam logic [11:0] idx_channel_power_down   = 12'h209;
  localparam logic [11:0] idx_extra_lane_enable_a  = 12'h20a;
  localparam logic [11:0] idx_extra_lane_enable_b  = 12'h20b;
  localparam logic [11:0] idx_calibration_control  = 12'h20c;

  localparam int          first_idx = 12'h200;
  localparam int          num_regs  = 13;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] rst_link_enable          = 8'h01;
  localparam logic [7:0] rst_output_mode          = 8'h02;
  localparam logic [7:0] rst_multiframe_length    = 8'h1f;
  localparam logic [7:0] rst_manual_sync_request  = 8'h01;
  localparam logic [7:0] rst_link_control         = 8'h02;
  localparam logic [7:0] rst_zero                 = 8'h00;

  // ==========================================================================
  // Field layouts
  localparam int          link_enable_bit   = 0;
  localparam int          soft_sync_bit     = 0;
  localparam int          cal_enable_bit    = 0;
  localparam int          mode_lsb          = 0;
  localparam int          mode_width        = 5;
  localparam int          kfield_lsb        = 0;
  localparam int          kfield_width      = 5;
  localparam int          sync_sel_lsb      = 2;
  localparam int          sync_sel_width    = 2;
  localparam logic [7:0]  mask_one_bit      = 8'h01;
  localparam logic [7:0]  mask_five_bits    = 8'h1f;
  localparam logic [7:0]  mask_four_bits    = 8'h0f;
  localparam logic [7:0]  mask_did          = 8'hfe;
  localparam logic [7:0]  mask_frame_character        = 8'h03;

  // Sync source select encodings
  localparam logic [1:0]  sync_src_single_ended = 2'h0;
  localparam logic [1:0]  sync_src_timestamp    = 2'h1;
  localparam logic [1:0]  sync_src_none         = 2'h2;

endpackage : link_regs_pkg

/* File: rtl/sync_two_ff.sv */
module sync_two_ff (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage_one;

  // Reset high so a floating pin does not raise a sync request at start-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= 1'b1;
      sync_out  <= 1'b1;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // sync_two_ff

/* File: rtl/serial_link_control_regs.sv */
// Function
// - Link enable bit 0, resets to one
// - Disabled link held in reset, serializers off
// - Disabled link has its clocks gated off
// - Disabled link holds multiframe counter in reset
// - Five-bit output mode field, resets 00010
// - Multiframe length holds frames minus one
// - Writing zero requests sync like pin
// - Software request works under any source
// - Stuck pin request persists until source two
// - Source select: pin, timestamp, or none
//
// Our own choice: the APB interface to the registers.
module serial_link_control_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        single_ended_sync_pin,
  input  wire logic        timestamp_diff_input,
  input  wire logic        sysref_in,
  input  wire logic [7:0]  link_status_in,
  output logic             link_enable,
  output logic             link_reset_n,
  output logic             serializer_power_down,
  output logic             link_clock_enable,
  output logic             lmfc_reset_n,
  output logic             sysref_to_lmfc,
  output logic             calibration_enable,
  output logic [4:0]       output_mode_select,
  output logic [4:0]       frames_per_multiframe_minus_one,
  output logic [1:0]       sync_source_select,
  output logic             sample_format_signed,
  output logic             scrambler_enable,
  output logic [3:0]       test_pattern_select,
  output logic [7:0]       device_id_param,
  output logic [1:0]       frame_character_select,
  output logic [7:0]       channel_power_down,
  output logic [7:0]       extra_lanes_link_a,
  output logic [7:0]       extra_lanes_link_b,
  output logic             sync_request_n
);

  // ==========================================================================
  // Register storage
  logic [7:0] regs [link_regs_pkg::num_regs];
  logic [7:0] next_regs [link_regs_pkg::num_regs];

  logic        word_aligned;
  logic [11:0] reg_index;
  logic        index_valid;
  logic [3:0]  slot;
  logic        wr_access;
  logic        sync_pin_se;
  logic        sync_pin_ts;
  logic        pin_request_n;

  assign word_aligned = (paddr[1:0] == 2'h0);
  assign reg_index    = paddr[13:2];
  assign index_valid  = word_aligned &&
                        (reg_index >= link_regs_pkg::idx_link_enable) &&
                        (reg_index <= link_regs_pkg::idx_calibration_control);
  assign slot         = 4'(reg_index - link_regs_pkg::idx_link_enable);
  assign wr_access    = psel && penable && pwrite && index_valid && pstrb[0];

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped or misaligned access
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !index_valid;

  // Writable bits per register; status register is read-only
  function automatic logic [7:0] write_mask(input logic [3:0] s);
    logic [11:0] i;
    i = 12'(link_regs_pkg::first_idx) + {8'h00, s};
    case (i)
      link_regs_pkg::idx_link_enable:          write_mask = link_regs_pkg::mask_one_bit;
      link_regs_pkg::idx_output_mode:          write_mask = link_regs_pkg::mask_five_bits;
      link_regs_pkg::idx_multiframe_length:    write_mask = link_regs_pkg::mask_five_bits;
      link_regs_pkg::idx_manual_sync_request:  write_mask = link_regs_pkg::mask_one_bit;
      link_regs_pkg::idx_link_control:         write_mask = link_regs_pkg::mask_four_bits;
      link_regs_pkg::idx_test_pattern_control: write_mask = link_regs_pkg::mask_four_bits;
      link_regs_pkg::idx_device_identifier:    write_mask = link_regs_pkg::mask_did;
      link_regs_pkg::idx_frame_character:      write_mask = link_regs_pkg::mask_frame_character;
      link_regs_pkg::idx_link_system_status:   write_mask = 8'h00;
      link_regs_pkg::idx_calibration_control:  write_mask = link_regs_pkg::mask_one_bit;
      default:                                 write_mask = 8'hff;
    endcase
  endfunction

  function automatic logic [7:0] reset_value(input logic [3:0] s);
    logic [11:0] i;
    i = 12'(link_regs_pkg::first_idx) + {8'h00, s};
    case (i)
      link_regs_pkg::idx_link_enable:         reset_value = link_regs_pkg::rst_link_enable;
      link_regs_pkg::idx_output_mode:         reset_value = link_regs_pkg::rst_output_mode;
      link_regs_pkg::idx_multiframe_length:   reset_value = link_regs_pkg::rst_multiframe_length;
      link_regs_pkg::idx_manual_sync_request: reset_value = link_regs_pkg::rst_manual_sync_request;
      link_regs_pkg::idx_link_control:        reset_value = link_regs_pkg::rst_link_control;
      default:                                reset_value = link_regs_pkg::rst_zero;
    endcase
  endfunction

  always_comb begin
    for (int k = 0; k < link_regs_pkg::num_regs; k++) begin
      next_regs[k] = regs[k];
    end
    if (wr_access) begin
      // Low lane only; upper lanes carry no storage
      next_regs[slot] = pwdata[7:0] & write_mask(slot);
    end
  end

  // Link enable, mode, frame length and sync bit all live in this bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < link_regs_pkg::num_regs; k++) begin
        regs[k] <= reset_value(4'(k));
      end
    end else begin
      for (int k = 0; k < link_regs_pkg::num_regs; k++) begin
        regs[k] <= next_regs[k];
      end
    end
  end

  // Read data registered on the setup phase so it is stable in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && index_valid) begin
      if (reg_index == link_regs_pkg::idx_link_system_status) begin
        prdata <= {24'h00_0000, link_status_in};
      end else begin
        prdata <= {24'h00_0000, regs[slot]};
      end
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Field decode
  localparam int s_en   = link_regs_pkg::idx_link_enable - link_regs_pkg::first_idx;
  localparam int s_mode = link_regs_pkg::idx_output_mode - link_regs_pkg::first_idx;
  localparam int s_k    = link_regs_pkg::idx_multiframe_length - link_regs_pkg::first_idx;
  localparam int s_sync = link_regs_pkg::idx_manual_sync_request - link_regs_pkg::first_idx;
  localparam int s_ctl  = link_regs_pkg::idx_link_control - link_regs_pkg::first_idx;
  localparam int s_tst  = link_regs_pkg::idx_test_pattern_control - link_regs_pkg::first_idx;
  localparam int s_did  = link_regs_pkg::idx_device_identifier - link_regs_pkg::first_idx;
  localparam int s_fch  = link_regs_pkg::idx_frame_character - link_regs_pkg::first_idx;
  localparam int s_pd   = link_regs_pkg::idx_channel_power_down - link_regs_pkg::first_idx;
  localparam int s_exa  = link_regs_pkg::idx_extra_lane_enable_a - link_regs_pkg::first_idx;
  localparam int s_exb  = link_regs_pkg::idx_extra_lane_enable_b - link_regs_pkg::first_idx;
  localparam int s_cal  = link_regs_pkg::idx_calibration_control - link_regs_pkg::first_idx;

  assign link_enable        = regs[s_en][link_regs_pkg::link_enable_bit];
  assign calibration_enable = regs[s_cal][link_regs_pkg::cal_enable_bit];
  assign output_mode_select = regs[s_mode][link_regs_pkg::mode_lsb +:
                                           link_regs_pkg::mode_width];
  assign frames_per_multiframe_minus_one =
    regs[s_k][link_regs_pkg::kfield_lsb +: link_regs_pkg::kfield_width];
  assign sync_source_select   = regs[s_ctl][link_regs_pkg::sync_sel_lsb +:
                                            link_regs_pkg::sync_sel_width];
  assign sample_format_signed = regs[s_ctl][1];
  assign scrambler_enable     = regs[s_ctl][0];
  assign test_pattern_select  = regs[s_tst][3:0];
  assign device_id_param      = regs[s_did];
  assign frame_character_select = regs[s_fch][1:0];
  assign channel_power_down   = regs[s_pd];
  assign extra_lanes_link_a   = regs[s_exa];
  assign extra_lanes_link_b   = regs[s_exb];

  // ==========================================================================
  // Link gating while disabled
  assign link_reset_n          = link_enable;
  assign serializer_power_down = !link_enable;
  assign link_clock_enable     = link_enable;
  // SYSREF is blocked too so a held counter cannot be realigned
  assign lmfc_reset_n          = link_enable;
  assign sysref_to_lmfc        = sysref_in && link_enable;

  // ==========================================================================
  // Sync request path
  sync_two_ff u_sync_se (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (single_ended_sync_pin),
    .sync_out (sync_pin_se)
  );

  sync_two_ff u_sync_ts (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (timestamp_diff_input),
    .sync_out (sync_pin_ts)
  );

  // Source 2 and unused code 3 ignore every pin, the only way out of a stuck pin
  always_comb begin
    case (sync_source_select)
      link_regs_pkg::sync_src_single_ended: pin_request_n = sync_pin_se;
      link_regs_pkg::sync_src_timestamp:    pin_request_n = sync_pin_ts;
      link_regs_pkg::sync_src_none:         pin_request_n = 1'b1;
      default:                              pin_request_n = 1'b1;
    endcase
  end

  // Registered so the request is glitch-free toward the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_request_n <= 1'b1;
    end else begin
      sync_request_n <= regs[s_sync][link_regs_pkg::soft_sync_bit] &&
                        pin_request_n;
    end
  end

endmodule // serial_link_control_regs

/* File: verification/link_regs_props.sv */
module link_regs_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        single_ended_sync_pin,
  input wire logic        timestamp_diff_input,
  input wire logic        sysref_in,
  input wire logic        link_enable,
  input wire logic        link_reset_n,
  input wire logic        serializer_power_down,
  input wire logic        link_clock_enable,
  input wire logic        lmfc_reset_n,
  input wire logic        sysref_to_lmfc,
  input wire logic [4:0]  output_mode_select,
  input wire logic [4:0]  frames_per_multiframe_minus_one,
  input wire logic [1:0]  sync_source_select,
  input wire logic        sync_request_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Sequences
  sequence wr_at(logic [13:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence soft_req;
    wr_at(14'h80c) ##0 !pwdata[0];
  endsequence
  // ==========================================================================
  // Checks
  enable_write_a: assert property (wr_at(14'h800) |=> link_enable == $past(pwdata[0]))
    else $error("link enable missed a write");
  reset_hold_a: assert property (link_reset_n == link_enable && serializer_power_down != link_enable)
    else $error("link reset or power down wrong");
  clock_gate_a: assert property (!link_enable |-> !link_clock_enable)
    else $error("link clock runs while disabled");
  lmfc_hold_a: assert property (!link_enable |-> !lmfc_reset_n && !sysref_to_lmfc)
    else $error("multiframe counter not held");
  mode_write_a: assert property (wr_at(14'h804) |=> output_mode_select == $past(pwdata[4:0]))
    else $error("mode field missed a write");
  kfield_write_a: assert property (wr_at(14'h808) |=> frames_per_multiframe_minus_one == $past(pwdata[4:0]))
    else $error("frame count missed a write");
  soft_sync_a: assert property (soft_req |=> ##1 !sync_request_n)
    else $error("software sync not raised");
  pin_sync_a: assert property ((sync_source_select == 2'h0 && !single_ended_sync_pin)[*4] |-> !sync_request_n)
    else $error("pin sync not raised");
  stamp_sync_a: assert property ((sync_source_select == 2'h1 && !timestamp_diff_input)[*4] |-> !sync_request_n)
    else $error("timestamp sync not raised");
endmodule // link_regs_props

bind serial_link_control_regs link_regs_props i_link_regs_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .sysref_in(sysref_in),
  .single_ended_sync_pin(single_ended_sync_pin), .timestamp_diff_input(timestamp_diff_input),
  .link_enable(link_enable), .link_reset_n(link_reset_n), .lmfc_reset_n(lmfc_reset_n),
  .serializer_power_down(serializer_power_down), .link_clock_enable(link_clock_enable),
  .sysref_to_lmfc(sysref_to_lmfc), .output_mode_select(output_mode_select),
  .frames_per_multiframe_minus_one(frames_per_multiframe_minus_one),
  .sync_source_select(sync_source_select), .sync_request_n(sync_request_n));

/* File: verification/sync_receiver.sv */
module sync_receiver (
  input  wire logic pclk,
  input  wire logic want_sync,
  input  wire logic on_stamp,
  output logic      single_ended_sync_pin = 1'b1,
  output logic      timestamp_diff_input  = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Receiver sync request, active low, moved only just after an edge
  always @(posedge pclk) begin
    single_ended_sync_pin <= !(want_sync && !on_stamp);
    timestamp_diff_input  <= !(want_sync && on_stamp);
  end
endmodule // sync_receiver

/* File: verification/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic [3:0]  pstrb = 4'h1;
  logic        sysref_in = 1'b1, want_sync = 1'b0, on_stamp = 1'b0, err_v;
  logic [7:0]  link_status_in = 8'h5a;
  logic        pready, pslverr, se_pin, ts_pin, link_enable, link_reset_n, link_clock_enable;
  logic        serializer_power_down, lmfc_reset_n, sysref_to_lmfc, calibration_enable;
  logic        sync_request_n;
  logic [4:0]  output_mode_select, frames_per_multiframe_minus_one;
  logic [1:0]  sync_source_select;
  logic [7:0]  rst_tab [13] = '{8'h01, 8'h02, 8'h1f, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00,
                                8'h5a, 8'h00, 8'h00, 8'h00, 8'h00};
  int          miscompares = 0, tests_run = 0;

  serial_link_control_regs i_serial_link_control_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_ended_sync_pin(se_pin), .timestamp_diff_input(ts_pin),
    .sysref_in(sysref_in), .link_status_in(link_status_in), .link_enable(link_enable),
    .link_reset_n(link_reset_n), .serializer_power_down(serializer_power_down),
    .link_clock_enable(link_clock_enable), .lmfc_reset_n(lmfc_reset_n),
    .sysref_to_lmfc(sysref_to_lmfc), .calibration_enable(calibration_enable),
    .output_mode_select(output_mode_select), .sync_source_select(sync_source_select),
    .frames_per_multiframe_minus_one(frames_per_multiframe_minus_one),
    .sample_format_signed(), .scrambler_enable(), .test_pattern_select(),
    .device_id_param(), .frame_character_select(), .channel_power_down(),
    .extra_lanes_link_a(), .extra_lanes_link_b(), .sync_request_n(sync_request_n));
  sync_receiver i_sync_receiver (.pclk(pclk), .want_sync(want_sync), .on_stamp(on_stamp),
    .single_ended_sync_pin(se_pin), .timestamp_diff_input(ts_pin));

  always #5 pclk = ~pclk;
  // ==========================================================================
  // Bus and compare helpers
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, {24'h0, d});
  endtask
  task automatic rdc(input string what, input logic [11:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(what, {24'h0, e}, rd_v);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int k = 0; k < 13; k++) rdc("reset value", 12'h200 + k[11:0], rst_tab[k]);
    $display("test reset done");
  endtask
  task automatic t_enable;
    wr(link_regs_pkg::idx_calibration_control, 8'h01);
    #1 chk("calibration enable", 32'h1, {31'h0, calibration_enable});
    wr(12'h200, 8'h00);
    #1 chk("gating off", 5'b01000, {link_reset_n, serializer_power_down, link_clock_enable, lmfc_reset_n, sysref_to_lmfc});
    wr(link_regs_pkg::idx_calibration_control, 8'h00);
    wr(12'h201, 8'hff);
    rdc("mode", 12'h201, 8'h1f);
    wr(12'h202, 8'he7);
    rdc("frames", 12'h202, 8'h07);
    chk("field outputs", 10'h3e7, {output_mode_select, frames_per_multiframe_minus_one});
    wr(link_regs_pkg::idx_calibration_control, 8'h01);
    wr(12'h200, 8'h01);
    #1 chk("gating on", 5'b10111, {link_reset_n, serializer_power_down, link_clock_enable, lmfc_reset_n, sysref_to_lmfc});
    $display("test enable done");
  endtask
  task automatic t_sync;
    for (int s = 0; s < 3; s++) begin
      wr(12'h200, 8'h00);
      wr(12'h204, {4'h0, s[1:0], 2'b10});
      wr(12'h200, 8'h01);
      on_stamp  <= (s == 1);
      want_sync <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("pin sync", {31'h0, s == 2}, {31'h0, sync_request_n});
      want_sync <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("pin release", 32'h1, {31'h0, sync_request_n});
    end
    want_sync <= 1'b1;
    on_stamp  <= 1'b0;
    wr(12'h203, 8'h00);
    repeat (2) @(posedge pclk);
    chk("soft sync", 32'h0, {31'h0, sync_request_n});
    wr(12'h203, 8'h01);
    repeat (2) @(posedge pclk);
    chk("stuck pin ignored", 32'h1, {31'h0, sync_request_n});
    want_sync <= 1'b0;
    $display("test sync done");
  endtask
  task automatic t_bad;
    apb(1'b1, 14'h834, 32'hff);
    chk("unmapped error", 32'h1, {31'h0, err_v});
    apb(1'b0, 14'h801, 32'h0);
    chk("misaligned error", 32'h1, {31'h0, err_v});
    chk("misaligned data", 32'h0, rd_v);
    wr(12'h208, 8'h00);
    rdc("status", 12'h208, 8'h5a);
    $display("test refusal done");
  endtask
  // ==========================================================================
  // Run control
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_enable;
    t_sync;
    t_bad;
    print_verdict;
  end
  // The whole run is under two hundred cycles, so 50 us means a hang
  initial begin
    #50us;
    miscompares++;
    print_verdict;
  end
endmodule // tb
